/* inc/ptic_pkg.sv */
// Shared constants and types for the program-table input control block.
// Assumes one 10 MHz clock and a synchronous active-high reset.
package ptic_pkg;

    // Width of the step number and number of select lines
    localparam int PTIC_STEP_W = 8;
    localparam int PTIC_SEL_N = 8;

    // Per-input polarity codes, shared by every discrete input
    localparam logic [1:0] PTIC_POL_CLOSED = 2'h0;
    localparam logic [1:0] PTIC_POL_OPEN = 2'h1;
    localparam logic [1:0] PTIC_POL_FORCE_ON = 2'h2;
    localparam logic [1:0] PTIC_POL_FORCE_OFF = 2'h3;

    // Reset values
    localparam logic [7:0] PTIC_STEP_RST = 8'h00;
    localparam logic [1:0] PTIC_POL_RST = 2'h0;

    // Serial command operations
    typedef enum logic [2:0]
    {
        PTIC_OP_NONE = 3'h0,
        PTIC_OP_START_STEP = 3'h1,
        PTIC_OP_STOP = 3'h2,
        PTIC_OP_RESUME = 3'h3,
        PTIC_OP_CANCEL = 3'h4
    } ptic_op_t;

    // Serial command as it arrives from the command decoder
    typedef struct packed
    {
        logic valid;
        ptic_op_t op;
        logic [7:0] step;
    } ptic_cmd_t;

    // Polarity settings of the run, cancel and select inputs; the mode pin has none
    typedef struct packed
    {
        logic [1:0] run;
        logic [1:0] cancel;
        logic [7:0][1:0] sel;
    } ptic_pol_t;

    // Sequence state
    typedef enum logic [1:0]
    {
        PTIC_ST_IDLE = 2'b00,
        PTIC_ST_RUN = 2'b01,
        PTIC_ST_HALT = 2'b10
    } ptic_state_t;

endpackage : ptic_pkg

/* logic/ptic_input_cell.sv */
// One discrete input: two-stage synchroniser, polarity and rising detect.
// Assumes the raw pin is asynchronous and the polarity code is steady.
`timescale 1ns/1ps
`default_nettype none

module ptic_input_cell
    import ptic_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic raw_in,
    input wire logic [1:0] pol,
    output logic active,
    output logic rise
);

    // Synchroniser stages; the first is read only by the second
    logic sync1_r;
    logic sync2_r;
    // Conditioned level and its next value
    logic active_r;
    logic active_nxt;

    // Two flip-flops before any logic looks at the pin
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end
        else
        begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
        end
    end

    // Polarity map; forced codes ignore the pin entirely
    always_comb
    begin
        // Safe value first, so no path leaves the level unassigned
        active_nxt = 1'b0;
        unique case (pol)
            PTIC_POL_CLOSED: active_nxt = sync2_r;
            PTIC_POL_OPEN: active_nxt = ~sync2_r;
            PTIC_POL_FORCE_ON: active_nxt = 1'b1;
            PTIC_POL_FORCE_OFF: active_nxt = 1'b0;
        endcase
    end

    // Conditioned level register
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            active_r <= 1'b0;
        else
            active_r <= active_nxt;
    end

    assign active = active_r;
    // One pulse per inactive-to-active change, hence one event per edge
    assign rise = active_nxt & ~active_r;

    property p_force_level;
        @(posedge clock) disable iff (sys_rst)
        (pol == PTIC_POL_FORCE_ON) |=> active;
    endproperty
    a_force_level: assert property (p_force_level)
        else $error("forced-on input not active");

endmodule : ptic_input_cell
`default_nettype wire

/* logic/ptic_control.sv */
// Program-table input control: discrete pins and serial commands steer
// run, halt, cancel and the selected step of the table sequencer.
// Assumes pins are asynchronous and polarity straps are stable at reset.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Run codes 0, 1: active run contact runs, inactive halts
// - Code 0: cancel on open-to-closed edge
// - Run code 0: closed means run
// - Run code 1: open means run
// - Run codes 2, 3 never start
// - Cancel code 1: cancel on closed-to-open
// - Cancel codes 2, 3 ignore the pin
// - Select codes 0, 1 set line sense
// - Select code 2 forces on, 3 off
// - Serial start-step, stop, resume, cancel commands
// - Serial control needs no mode input
// - Serial control needs no discrete wiring
// - Select lines form binary step, bit0 LSB
// - Discrete control only in program mode
module ptic_control
    import ptic_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic mode_select_in,
    input wire logic run_halt_in,
    input wire logic sequence_cancel_input,
    input wire logic step_select_bit0,
    input wire logic step_select_bit1,
    input wire logic step_select_bit2,
    input wire logic step_select_bit3,
    input wire logic step_select_bit4,
    input wire logic step_select_bit5,
    input wire logic step_select_bit6,
    input wire logic step_select_bit7,
    input wire ptic_pol_t pol_settings,
    input wire ptic_cmd_t serial_cmd,
    output logic program_mode,
    output logic seq_running,
    output logic seq_halted,
    output logic serial_control,
    output logic seq_cancel,
    output logic step_load,
    output logic [7:0] table_step_number
);

    // Polarity copy taken at restart
    ptic_pol_t pol_r;
    // Effective codes after the never-start / never-cancel mapping
    logic [1:0] run_code;
    logic [1:0] cancel_code;
    // Conditioned inputs
    logic mode_act;
    logic run_act;
    logic cancel_rise;
    logic [7:0] sel_raw;
    logic [7:0] sel_act;
    // Discrete events
    logic disc_run;
    logic disc_run_prev_r;
    logic disc_start;
    logic disc_cancel;
    logic ser_cancel;
    // Sequence state and outputs
    ptic_state_t st_r;
    logic serial_r;
    logic cancel_r;
    logic load_r;
    logic [7:0] step_r;

    // straps captured only while restart holds
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            pol_r <= pol_settings;
    end

    // codes 2 and 3 both mean never run
    assign run_code = pol_r.run[1] ? PTIC_POL_FORCE_OFF : pol_r.run;
    // codes 2 and 3 both leave cancel dead
    assign cancel_code = pol_r.cancel[1] ? PTIC_POL_FORCE_OFF : pol_r.cancel;

    // Mode pin has no setting of its own here: closed is program mode
    ptic_input_cell u_mode
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .raw_in(mode_select_in),
        .pol(PTIC_POL_CLOSED),
        .active(mode_act),
        .rise()
    );

    ptic_input_cell u_run
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .raw_in(run_halt_in),
        .pol(run_code),
        .active(run_act),
        .rise()
    );

    ptic_input_cell u_cancel
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .raw_in(sequence_cancel_input),
        .pol(cancel_code),
        .active(),
        .rise(cancel_rise)
    );

    // Select pins gathered, bit 0 lowest
    assign sel_raw = {step_select_bit7, step_select_bit6, step_select_bit5, step_select_bit4,
                      step_select_bit3, step_select_bit2, step_select_bit1, step_select_bit0};

    // each select line with its own code
    genvar gi;
    generate
        for (gi = 0; gi < PTIC_SEL_N; gi++)
        begin : g_sel
            ptic_input_cell u_sel
            (
                .clock(clock),
                .sys_rst(sys_rst),
                .raw_in(sel_raw[gi]),
                .pol(pol_r.sel[gi]),
                .active(sel_act[gi]),
                .rise()
            );
        end
    endgenerate

    // discrete requests only count in program mode
    assign disc_run = mode_act & run_act;
    assign disc_cancel = mode_act & cancel_rise;
    // A start needs a fresh run request, so a held contact after cancel waits
    assign disc_start = disc_run & ~disc_run_prev_r;
    assign ser_cancel = serial_cmd.valid & (serial_cmd.op == PTIC_OP_CANCEL);

    // Previous discrete run request for edge detect
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            disc_run_prev_r <= 1'b0;
        else
            disc_run_prev_r <= disc_run;
    end

    // Sequence control; cancel beats everything, serial beats discrete
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            st_r <= PTIC_ST_IDLE;
            serial_r <= 1'b0;
            cancel_r <= 1'b0;
            load_r <= 1'b0;
            step_r <= PTIC_STEP_RST;
        end
        else
        begin
            cancel_r <= 1'b0;
            load_r <= 1'b0;
            if (ser_cancel || disc_cancel)
            begin
                st_r <= PTIC_ST_IDLE;
                cancel_r <= 1'b1;
            end
            // serial commands work without mode or pins
            else if (serial_cmd.valid)
            begin
                unique case (serial_cmd.op)
                    PTIC_OP_START_STEP:
                    begin
                        step_r <= serial_cmd.step;
                        load_r <= 1'b1;
                        st_r <= PTIC_ST_RUN;
                        serial_r <= 1'b1;
                    end
                    PTIC_OP_RESUME:
                    begin
                        st_r <= PTIC_ST_RUN;
                        serial_r <= 1'b1;
                    end
                    PTIC_OP_STOP:
                    begin
                        // Only a running sequence has something to halt
                        if (st_r == PTIC_ST_RUN)
                            st_r <= PTIC_ST_HALT;
                        serial_r <= 1'b1;
                    end
                    default:
                    begin
                        // Unknown operation is ignored
                        st_r <= st_r;
                    end
                endcase
            end
            // discrete start takes the selected step
            else if (disc_start)
            begin
                step_r <= sel_act;
                load_r <= 1'b1;
                st_r <= PTIC_ST_RUN;
                serial_r <= 1'b0;
            end
            // discrete halt when run request drops
            else if (st_r == PTIC_ST_RUN && !serial_r && !disc_run)
            begin
                st_r <= PTIC_ST_HALT;
            end
        end
    end

    // Outputs
    assign program_mode = mode_act;
    assign seq_running = (st_r == PTIC_ST_RUN);
    assign seq_halted = (st_r == PTIC_ST_HALT);
    assign serial_control = serial_r;
    assign seq_cancel = cancel_r;
    assign step_load = load_r;
    assign table_step_number = step_r;

    // Cancel request seen, in either form
    sequence s_cancel_req;
        disc_cancel || ser_cancel;
    endsequence

    // Cancel answered by pulse and idle
    sequence s_cancel_done;
        seq_cancel && st_r == PTIC_ST_IDLE;
    endsequence

    // Back-to-back serial cancels are legal, so each request is checked on its own
    property p_cancel_edge;
        @(posedge clock) disable iff (sys_rst)
        s_cancel_req |=> s_cancel_done;
    endproperty
    a_cancel_edge: assert property (p_cancel_edge)
        else $error("cancel not answered by pulse and idle");

    // No pulse without a request, so one edge gives one pulse
    property p_cancel_single;
        @(posedge clock) disable iff (sys_rst)
        !(disc_cancel || ser_cancel) |=> !seq_cancel;
    endproperty
    a_cancel_single: assert property (p_cancel_single)
        else $error("cancel pulse without a request");

    property p_cancel_off;
        @(posedge clock) disable iff (sys_rst)
        pol_r.cancel[1] |-> !cancel_rise;
    endproperty
    a_cancel_off: assert property (p_cancel_off)
        else $error("cancel edge seen while cancel pin disabled");

    property p_no_start;
        @(posedge clock) disable iff (sys_rst)
        pol_r.run[1] |-> !disc_start;
    endproperty
    a_no_start: assert property (p_no_start)
        else $error("discrete start with run pin disabled");

    property p_disc_halt;
        @(posedge clock) disable iff (sys_rst)
        (seq_running && !serial_r && !disc_run && !serial_cmd.valid && !disc_cancel)
            |=> seq_halted;
    endproperty
    a_disc_halt: assert property (p_disc_halt)
        else $error("discrete run dropped but sequence kept running");

    property p_step_decode;
        @(posedge clock) disable iff (sys_rst)
        (disc_start && !serial_cmd.valid && !disc_cancel)
            |=> step_load && seq_running && table_step_number == $past(sel_act);
    endproperty
    a_step_decode: assert property (p_step_decode)
        else $error("discrete start loaded wrong step");

    property p_serial_start;
        @(posedge clock) disable iff (sys_rst)
        (serial_cmd.valid && serial_cmd.op == PTIC_OP_START_STEP && !disc_cancel)
            |=> seq_running && serial_r && table_step_number == $past(serial_cmd.step);
    endproperty
    a_serial_start: assert property (p_serial_start)
        else $error("serial start did not load and run");

    property p_mode_gate;
        @(posedge clock) disable iff (sys_rst)
        !mode_act |-> !disc_start && !disc_cancel;
    endproperty
    a_mode_gate: assert property (p_mode_gate)
        else $error("discrete event outside program mode");

    property p_pol_hold;
        @(posedge clock) disable iff (sys_rst)
        !$past(sys_rst) |-> $stable(pol_r);
    endproperty
    a_pol_hold: assert property (p_pol_hold)
        else $error("polarity copy changed outside restart");

endmodule : ptic_control
`default_nettype wire

/* tb/ptic_host_model.sv */
// Host model: drives the discrete pins and the serial command port.
// Assumes the bench calls its tasks; every change lands at a falling edge.
`timescale 1ns/1ps
`default_nettype none
module ptic_host_model
    import ptic_pkg::*;
(
    input wire logic clock,
    output logic mode_pin,
    output logic run_pin,
    output logic cancel_pin,
    output logic [7:0] sel_pin,
    output var ptic_cmd_t cmd
);
    // Pins open, command port quiet at start
    initial
    begin
        {mode_pin, run_pin, cancel_pin, sel_pin} = 11'h000;
        cmd = 12'h000;
    end

    // Pin levels change off the sampling edge
    task automatic pins(input logic m, r, c, input logic [7:0] s);
        @(negedge clock);
        {mode_pin, run_pin, cancel_pin, sel_pin} = {m, r, c, s};
    endtask : pins

    task automatic send(input ptic_op_t op, input logic [7:0] st);
        @(negedge clock);
        cmd = {1'b1, op, st};
        @(negedge clock);
        // Idle fields scrambled so a stale command never looks valid by luck
        cmd = {1'b0, ~op, ~st};
    endtask : send
endmodule : ptic_host_model
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench: serial commands and discrete pins against a local model.
// Assumes the host model drives all pins and commands at falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb
    import ptic_pkg::*;
;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    ptic_pol_t pol = 20'h00000;
    ptic_pol_t lat;
    ptic_pol_t p;
    logic mode, run, cnl, prog, running, halted, ser, cancel, load, ri, ci;
    logic [7:0] sel, step, raw, exp_s;
    ptic_cmd_t cmd;
    // Model of the sequence state
    logic e_run, e_halt, e_ser;
    logic [7:0] e_step;
    logic [31:0] seed = 32'hed9fde4c;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;

    ptic_host_model host (.clock(clock), .mode_pin(mode), .run_pin(run), .cancel_pin(cnl),
        .sel_pin(sel), .cmd(cmd));
    ptic_control dut (.clock(clock), .sys_rst(sys_rst), .mode_select_in(mode),
        .run_halt_in(run), .sequence_cancel_input(cnl), .step_select_bit0(sel[0]),
        .step_select_bit1(sel[1]), .step_select_bit2(sel[2]), .step_select_bit3(sel[3]),
        .step_select_bit4(sel[4]), .step_select_bit5(sel[5]), .step_select_bit6(sel[6]),
        .step_select_bit7(sel[7]), .pol_settings(pol), .serial_cmd(cmd),
        .program_mode(prog), .seq_running(running), .seq_halted(halted),
        .serial_control(ser), .seq_cancel(cancel), .step_load(load),
        .table_step_number(step));

    // 10 MHz clock
    always #50 clock = ~clock;

    // Hang guard, far above the planned run
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            end_sim();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    // Flag compare
    task automatic chk1(input string nm, input logic e, input logic g);
        comparisons++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1

    // Byte compare
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8

    // Output levels against the model
    task automatic cmp_state();
        chk1("program_mode", mode, prog);
        chk1("seq_running", e_run, running);
        chk1("seq_halted", e_halt, halted);
        chk1("serial_control", e_ser, ser);
        chk8("table_step_number", e_step, step);
    endtask : cmp_state

    // Ten reset cycles; polarity is scrambled after release to prove it was latched
    task automatic do_reset(input ptic_pol_t pv);
        @(negedge clock);
        pol = pv;
        lat = pv;
        sys_rst = 1'b1;
        repeat (10) @(negedge clock);
        sys_rst = 1'b0;
        seed = lfsr(seed);
        pol = seed[19:0];
        {e_run, e_halt, e_ser, e_step} = 11'h000;
    endtask : do_reset

    // Pulses over ten cycles; a pin event lands within four
    task automatic pulses(input logic want_cancel, output int cnt);
        cnt = 0;
        repeat (10)
        begin
            @(negedge clock);
            if ((want_cancel ? cancel : load) === 1'b1)
                cnt++;
        end
    endtask : pulses

    // One serial command, then the model's view of it
    task automatic ser_cmd(input ptic_op_t op);
        seed = lfsr(seed);
        host.send(op, seed[7:0]);
        if (op == PTIC_OP_START_STEP)
            e_step = seed[7:0];
        case (op)
            PTIC_OP_START_STEP, PTIC_OP_RESUME: {e_run, e_halt, e_ser} = 3'h5;
            PTIC_OP_STOP: {e_run, e_halt, e_ser} = {1'b0, e_run | e_halt, 1'b1};
            PTIC_OP_CANCEL: {e_run, e_halt, e_ser} = 3'h1;
            default: ;
        endcase
        chk1("seq_cancel", op == PTIC_OP_CANCEL, cancel);
        if (op == PTIC_OP_START_STEP)
            chk1("step_load", 1'b1, load);
        cmp_state();
    endtask : ser_cmd

    initial
    begin
        // Serial control with the mode pin inactive and pins unwired
        do_reset(20'h00000);
        cmp_state();
        ser_cmd(PTIC_OP_START_STEP);
        ser_cmd(PTIC_OP_STOP);
        ser_cmd(PTIC_OP_RESUME);
        ser_cmd(PTIC_OP_START_STEP);
        ser_cmd(PTIC_OP_CANCEL);
        ser_cmd(PTIC_OP_STOP);
        ser_cmd(PTIC_OP_RESUME);
        ser_cmd(ptic_op_t'(3'h6));
        ser_cmd(PTIC_OP_CANCEL);
        // Discrete control, one run and cancel polarity code per pass, select codes random
        for (int c = 0; c < 4; c++)
        begin
            seed = lfsr(seed);
            raw = seed[7:0];
            p = {2'(c), 2'(c), seed[31:16]};
            ri = (c == 1);
            ci = (c == 1);
            host.pins(1'b1, ri, ci, raw);
            do_reset(p);
            for (int i = 0; i < 8; i++)
                exp_s[i] = lat.sel[i][1] ? ~lat.sel[i][0] : lat.sel[i][0] ^ raw[i];
            host.pins(1'b1, ~ri, ci, raw);
            pulses(1'b0, n);
            chk8("start_count", 8'(c < 2), 8'(n));
            if (c < 2)
                {e_run, e_step} = {1'b1, exp_s};
            cmp_state();
            host.pins(1'b1, ri, ci, raw);
            repeat (8) @(negedge clock);
            if (c < 2)
                {e_run, e_halt} = 2'b01;
            cmp_state();
            host.pins(1'b1, ~ri, ci, raw);
            pulses(1'b0, n);
            chk8("restart_count", 8'(c < 2), 8'(n));
            if (c < 2)
                {e_run, e_halt} = 2'b10;
            host.pins(1'b1, ~ri, ~ci, raw);
            pulses(1'b1, n);
            chk8("cancel_count", 8'(c < 2), 8'(n));
            if (c < 2)
                {e_run, e_halt} = 2'b00;
            cmp_state();
            // Mode off; cancel returns to rest without a live edge
            host.pins(1'b0, ri, ci, raw);
            pulses(1'b0, n);
            host.pins(1'b0, ~ri, ci, raw);
            pulses(1'b0, n);
            chk8("idle_mode_count", 8'h00, 8'(n));
            // Live cancel edge with mode off must be dropped
            host.pins(1'b0, ~ri, ~ci, raw);
            pulses(1'b1, n);
            chk8("idle_cancel_count", 8'h00, 8'(n));
            cmp_state();
        end
        end_sim();
    end

    // Counts, verdict and end of run
    task automatic end_sim();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim
endmodule : tb
`default_nettype wire
